// ### hdl/fpc_pkg.sv
// Constants, types and helpers for the fast parallel configuration port.
package fpc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCF2CD_NS = 600;
    localparam int TCF2CD_CYC = TCF2CD_NS / CLK_PERIOD_NS;
    localparam int TSTATUS_MIN_US = 268;
    localparam int TSTATUS_MIN_CYC = (TSTATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TSTATUS_MAX_US = 1506;
    localparam int TSTATUS_MAX_CYC = (TSTATUS_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int TCD2UM_MIN_US = 175;
    localparam int TCD2UM_MIN_CYC = (TCD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCD2UM_MAX_US = 437;
    localparam int TCD2UM_MAX_CYC = (TCD2UM_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int LCLK_MAX_PERIOD_NS = 10;
    localparam int TCD2CU_NS = 4 * LCLK_MAX_PERIOD_NS;
    localparam int TCD2CU_CYC = (TCD2CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int USR_INIT_EDGES = 8576;
    localparam int POR_DELAY_US = 100;
    localparam int POR_CYC = (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_W = 32;
    localparam int CNT_W = 20;
    localparam int WCNT_W = 24;
    localparam int PHASE_W = 3;
    localparam int RATIO_W = 4;
    localparam int CTRL_W = 6;
    localparam logic [1:0] BUS_X8 = 2'h0;
    localparam logic [1:0] BUS_X16 = 2'h1;
    localparam logic [1:0] BUS_X32 = 2'h2;
    localparam logic [RATIO_W-1:0] RATIO_1 = 4'h1;
    localparam logic [RATIO_W-1:0] RATIO_2 = 4'h2;
    localparam logic [RATIO_W-1:0] RATIO_4 = 4'h4;
    localparam logic [RATIO_W-1:0] RATIO_8 = 4'h8;
    localparam int CTRL_WIDTH_LSB = 0;
    localparam int CTRL_DECOMP_BIT = 2;
    localparam int CTRL_SECUR_BIT = 3;
    localparam int CTRL_USRCLK_BIT = 4;
    localparam int CTRL_INITDN_BIT = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h02;
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_IMAGE_WORDS = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_WORDS_RX = 5'h0c;
    localparam logic [4:0] ADDR_LAST_WORD = 5'h10;
    localparam logic [WCNT_W-1:0] IMAGE_WORDS_RESET = 24'h00_0010;
    localparam int STAT_LOADING_BIT = 0;
    localparam int STAT_COMPLETE_BIT = 1;
    localparam int STAT_USER_BIT = 2;
    localparam int STAT_STLOW_BIT = 3;
    localparam int STAT_RATIO_LSB = 4;

    typedef enum logic [2:0] {
        ST_POR, ST_HOLD, ST_STATUS_LOW, ST_WAIT_REL, ST_LOAD, ST_DONE_WAIT, ST_INIT, ST_USER
    } fpc_state_t;

    function automatic logic [RATIO_W-1:0] fpc_ratio(input logic [1:0] width,
                                                     input logic decomp, input logic secur);
        fpc_ratio = RATIO_1;
        case (width)
            BUS_X8: fpc_ratio = decomp ? RATIO_2 : RATIO_1;
            BUS_X16: fpc_ratio = decomp ? RATIO_4 : (secur ? RATIO_2 : RATIO_1);
            default: fpc_ratio = decomp ? RATIO_8 : (secur ? RATIO_4 : RATIO_1);
        endcase
    endfunction
endpackage

// ### hdl/fpc_port.sv
// Device-side fast parallel configuration port with an AHB-Lite register slave.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module fpc_port #(
    parameter int POR_CYC = fpc_pkg::POR_CYC,
    parameter int STATUS_MIN_CYC = fpc_pkg::TSTATUS_MIN_CYC,
    parameter int STATUS_MAX_CYC = fpc_pkg::TSTATUS_MAX_CYC,
    parameter int INIT_CYC = fpc_pkg::TCD2UM_MIN_CYC,
    parameter int INIT_MAX_CYC = fpc_pkg::TCD2UM_MAX_CYC,
    parameter int USR_EDGES = fpc_pkg::USR_INIT_EDGES
) (
    // Clock, reset and enable.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Configuration pins.
    input wire logic load_clock,
    input wire logic [31:0] config_data,
    input wire logic config_request_n,
    input wire logic config_status_n_i,
    output logic config_status_n_o,
    output logic config_status_n_oe,
    output logic config_complete_o,
    output logic config_complete_oe,
    input wire logic user_init_clock,
    output logic init_done_o,
    output logic init_done_oe,
    output logic user_io_en,
    output logic user_clk_en
);
    typedef struct packed {
        fpc_pkg::fpc_state_t state;
        logic req_s1;
        logic req_s2;
        logic st_s1;
        logic st_s2;
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic uclk_s1;
        logic uclk_s2;
        logic uclk_s3;
        logic [31:0] dat_s1;
        logic [31:0] dat_s2;
        logic [fpc_pkg::CTRL_W-1:0] ctrl;
        logic [fpc_pkg::WCNT_W-1:0] target;
        logic [fpc_pkg::WCNT_W-1:0] words;
        logic [31:0] last_word;
        logic [fpc_pkg::PHASE_W-1:0] phase;
        logic [fpc_pkg::CNT_W-1:0] cnt;
        logic [1:0] falls;
        logic status_oe;
        logic complete_oe;
        logic initdn_oe;
        logic user_io;
        logic usrclk_en;
        logic pend;
        logic a_wr;
        logic a_hit;
        logic [4:0] a_addr;
        logic [31:0] rdata;
        logic readyout;
    } fpc_st_t;

    fpc_st_t s_ff;
    fpc_st_t nxt_s;
    logic lclk_rise;
    logic lclk_fall;
    logic uclk_rise;
    logic [fpc_pkg::RATIO_W-1:0] ratio;
    logic [31:0] masked;
    logic [31:0] status_word;

    assign lclk_rise = s_ff.clk_s2 & ~s_ff.clk_s3;
    assign lclk_fall = ~s_ff.clk_s2 & s_ff.clk_s3;
    assign uclk_rise = s_ff.uclk_s2 & ~s_ff.uclk_s3;
    // The ratio is frozen by software before a load; changing it mid-image corrupts the load.
    assign ratio = fpc_pkg::fpc_ratio(s_ff.ctrl[fpc_pkg::CTRL_WIDTH_LSB +: 2],
                                      s_ff.ctrl[fpc_pkg::CTRL_DECOMP_BIT],
                                      s_ff.ctrl[fpc_pkg::CTRL_SECUR_BIT]);

    always_comb begin
        masked = s_ff.dat_s2;
        case (s_ff.ctrl[fpc_pkg::CTRL_WIDTH_LSB +: 2])
            fpc_pkg::BUS_X8: masked = {24'h00_0000, s_ff.dat_s2[7:0]};
            fpc_pkg::BUS_X16: masked = {16'h0000, s_ff.dat_s2[15:0]};
            default: masked = s_ff.dat_s2;
        endcase
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[fpc_pkg::STAT_LOADING_BIT] = (s_ff.state == fpc_pkg::ST_LOAD);
        status_word[fpc_pkg::STAT_COMPLETE_BIT] = ~s_ff.complete_oe;
        status_word[fpc_pkg::STAT_USER_BIT] = (s_ff.state == fpc_pkg::ST_USER);
        status_word[fpc_pkg::STAT_STLOW_BIT] = s_ff.status_oe;
        status_word[fpc_pkg::STAT_RATIO_LSB +: fpc_pkg::RATIO_W] = ratio;
    end

    always_comb begin
        nxt_s = s_ff;
        nxt_s.req_s1 = config_request_n;
        nxt_s.req_s2 = s_ff.req_s1;
        nxt_s.st_s1 = config_status_n_i;
        nxt_s.st_s2 = s_ff.st_s1;
        nxt_s.clk_s1 = load_clock;
        nxt_s.clk_s2 = s_ff.clk_s1;
        nxt_s.clk_s3 = s_ff.clk_s2;
        nxt_s.uclk_s1 = user_init_clock;
        nxt_s.uclk_s2 = s_ff.uclk_s1;
        nxt_s.uclk_s3 = s_ff.uclk_s2;
        nxt_s.dat_s1 = config_data;
        nxt_s.dat_s2 = s_ff.dat_s1;

        case (s_ff.state)
            fpc_pkg::ST_POR: begin
                nxt_s.cnt = s_ff.cnt + 1'b1;
                if (s_ff.cnt == fpc_pkg::CNT_W'(POR_CYC - 1)) begin
                    nxt_s.status_oe = 1'b0;
                    nxt_s.state = fpc_pkg::ST_WAIT_REL;
                end
            end
            fpc_pkg::ST_HOLD: begin
                nxt_s.cnt = '0;
                if (s_ff.req_s2) begin
                    nxt_s.state = fpc_pkg::ST_STATUS_LOW;
                end
            end
            fpc_pkg::ST_STATUS_LOW: begin
                nxt_s.cnt = s_ff.cnt + 1'b1;
                if (s_ff.cnt == fpc_pkg::CNT_W'(STATUS_MIN_CYC - 1)) begin
                    nxt_s.status_oe = 1'b0;
                    nxt_s.state = fpc_pkg::ST_WAIT_REL;
                end
            end
            fpc_pkg::ST_WAIT_REL: begin
                // An outside party may keep status low to delay configuration.
                if (s_ff.st_s2) begin
                    nxt_s.words = '0;
                    nxt_s.phase = '0;
                    nxt_s.state = fpc_pkg::ST_LOAD;
                end
            end
            fpc_pkg::ST_LOAD: begin
                nxt_s.initdn_oe = s_ff.ctrl[fpc_pkg::CTRL_INITDN_BIT];
                if (lclk_rise) begin
                    // Words are taken only on phase zero; the host holds them for the rest.
                    if (s_ff.phase == '0 && s_ff.words != s_ff.target) begin
                        nxt_s.last_word = masked;
                        nxt_s.words = s_ff.words + 1'b1;
                    end
                    if (s_ff.phase == fpc_pkg::PHASE_W'(ratio - 1'b1)) begin
                        nxt_s.phase = '0;
                    end else begin
                        nxt_s.phase = s_ff.phase + 1'b1;
                    end
                end
                // Trailing edges after the last word return the phase to zero.
                if (s_ff.words == s_ff.target && s_ff.target != '0 && s_ff.phase == '0) begin
                    nxt_s.complete_oe = 1'b0;
                    nxt_s.falls = '0;
                    nxt_s.state = fpc_pkg::ST_DONE_WAIT;
                end
            end
            fpc_pkg::ST_DONE_WAIT: begin
                if (lclk_fall) begin
                    nxt_s.falls = s_ff.falls + 1'b1;
                    if (s_ff.falls == 2'h1) begin
                        nxt_s.cnt = '0;
                        nxt_s.state = fpc_pkg::ST_INIT;
                    end
                end
            end
            fpc_pkg::ST_INIT: begin
                if (!s_ff.ctrl[fpc_pkg::CTRL_USRCLK_BIT]) begin
                    nxt_s.cnt = s_ff.cnt + 1'b1;
                    if (s_ff.cnt == fpc_pkg::CNT_W'(INIT_CYC - 1)) begin
                        nxt_s.state = fpc_pkg::ST_USER;
                    end
                end else if (!s_ff.usrclk_en) begin
                    nxt_s.cnt = s_ff.cnt + 1'b1;
                    if (s_ff.cnt == fpc_pkg::CNT_W'(fpc_pkg::TCD2CU_CYC - 1)) begin
                        nxt_s.usrclk_en = 1'b1;
                        nxt_s.cnt = '0;
                    end
                end else if (uclk_rise) begin
                    nxt_s.cnt = s_ff.cnt + 1'b1;
                    if (s_ff.cnt == fpc_pkg::CNT_W'(USR_EDGES - 1)) begin
                        nxt_s.state = fpc_pkg::ST_USER;
                    end
                end
            end
            fpc_pkg::ST_USER: begin
                // The load clock has no effect here.
                nxt_s.user_io = 1'b1;
                nxt_s.initdn_oe = 1'b0;
                nxt_s.usrclk_en = 1'b0;
            end
            default: nxt_s.state = fpc_pkg::ST_POR;
        endcase

        if (!s_ff.req_s2) begin
            nxt_s.state = fpc_pkg::ST_HOLD;
            nxt_s.status_oe = 1'b1;
            nxt_s.complete_oe = 1'b1;
            nxt_s.user_io = 1'b0;
            nxt_s.initdn_oe = 1'b0;
            nxt_s.usrclk_en = 1'b0;
        end

        // Every transfer takes one wait state so that read data leaves a flip-flop.
        nxt_s.readyout = 1'b1;
        if (s_ff.pend) begin
            nxt_s.pend = 1'b0;
            nxt_s.rdata = 32'h0000_0000;
            if (s_ff.a_hit && s_ff.a_wr) begin
                case (s_ff.a_addr)
                    fpc_pkg::ADDR_CTRL: nxt_s.ctrl = hwdata[fpc_pkg::CTRL_W-1:0];
                    fpc_pkg::ADDR_IMAGE_WORDS: nxt_s.target = hwdata[fpc_pkg::WCNT_W-1:0];
                    default: nxt_s.rdata = 32'h0000_0000;
                endcase
            end else if (s_ff.a_hit) begin
                case (s_ff.a_addr)
                    fpc_pkg::ADDR_CTRL: nxt_s.rdata = {26'h000_0000, s_ff.ctrl};
                    fpc_pkg::ADDR_IMAGE_WORDS: nxt_s.rdata = {8'h00, s_ff.target};
                    fpc_pkg::ADDR_STATUS: nxt_s.rdata = status_word;
                    fpc_pkg::ADDR_WORDS_RX: nxt_s.rdata = {8'h00, s_ff.words};
                    fpc_pkg::ADDR_LAST_WORD: nxt_s.rdata = s_ff.last_word;
                    default: nxt_s.rdata = 32'h0000_0000;
                endcase
            end
        end else if (hsel && htrans[1] && hready) begin
            nxt_s.pend = 1'b1;
            nxt_s.readyout = 1'b0;
            nxt_s.a_wr = hwrite;
            nxt_s.a_addr = haddr[4:0];
            nxt_s.a_hit = (haddr[31:5] == 27'h000_0000) && (haddr[1:0] == 2'h0);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
            s_ff.state <= fpc_pkg::ST_POR;
            s_ff.req_s1 <= 1'b1;
            s_ff.req_s2 <= 1'b1;
            s_ff.ctrl <= fpc_pkg::CTRL_RESET;
            s_ff.target <= fpc_pkg::IMAGE_WORDS_RESET;
            s_ff.status_oe <= 1'b1;
            s_ff.complete_oe <= 1'b1;
            s_ff.readyout <= 1'b1;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign hrdata = s_ff.rdata;
    assign hreadyout = s_ff.readyout;
    assign hresp = 1'b0;
    assign config_status_n_o = 1'b0;
    assign config_status_n_oe = s_ff.status_oe;
    assign config_complete_o = 1'b0;
    assign config_complete_oe = s_ff.complete_oe;
    assign init_done_o = 1'b0;
    assign init_done_oe = s_ff.initdn_oe;
    assign user_io_en = s_ff.user_io;
    assign user_clk_en = s_ff.usrclk_en;

    // Helper counter for the timing checks below.
    logic [fpc_pkg::CNT_W-1:0] chk_init_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chk_init_cnt <= '0;
        end else if (ce) begin
            chk_init_cnt <= (s_ff.state == fpc_pkg::ST_INIT) ? chk_init_cnt + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence seq_capture;
        ce && s_ff.state == fpc_pkg::ST_LOAD && lclk_rise && s_ff.phase == '0 &&
            s_ff.words != s_ff.target;
    endsequence
    // Watch the request after its synchroniser, so the first stage stays private to it.
    sequence seq_req_fall;
        ce && $fell(s_ff.req_s2);
    endsequence
    sequence seq_init_entry;
        ce && $rose(s_ff.state == fpc_pkg::ST_INIT);
    endsequence

    a_ratio_x32_dec: assert property (s_ff.ctrl[1:0] == fpc_pkg::BUS_X32 && s_ff.ctrl[2]
        |-> ratio == 4'h8) else $error("ratio not 8 for 32-bit decompression");
    a_ratio_x16_sec: assert property (s_ff.ctrl[1:0] == fpc_pkg::BUS_X16 && !s_ff.ctrl[2]
        && s_ff.ctrl[3] |-> ratio == 4'h2) else $error("ratio not 2 for 16-bit security");
    a_word_capture: assert property (seq_capture |=> s_ff.words == $past(s_ff.words) + 1'b1
        && s_ff.last_word == $past(masked)) else $error("word not captured");
    a_width_mask: assert property (s_ff.ctrl[1:0] == fpc_pkg::BUS_X8 |-> masked[31:8] == '0)
        else $error("upper bus bits leak into 8-bit load");
    // The synchroniser and the output register take three cycles, well inside 600 ns.
    a_req_response: assert property (seq_req_fall |-> ##[1:3]
        (s_ff.status_oe && s_ff.complete_oe)) else $error("slow request response");
    a_load_not_done: assert property (s_ff.state == fpc_pkg::ST_LOAD && $past(s_ff.state)
        == fpc_pkg::ST_LOAD |-> s_ff.complete_oe) else $error("complete during load");
    a_done_full: assert property ($fell(s_ff.complete_oe) |-> s_ff.words == s_ff.target)
        else $error("complete before image end");
    a_status_min: assert property ($fell(s_ff.status_oe) && $past(s_ff.state) ==
        fpc_pkg::ST_STATUS_LOW |-> $past(s_ff.cnt) == fpc_pkg::CNT_W'(STATUS_MIN_CYC - 1))
        else $error("status pulse length wrong");
    a_status_max: assert property (s_ff.state == fpc_pkg::ST_STATUS_LOW |->
        s_ff.cnt < fpc_pkg::CNT_W'(STATUS_MAX_CYC)) else $error("status held too long");
    a_user_pins: assert property (s_ff.state == fpc_pkg::ST_USER && $past(s_ff.state) ==
        fpc_pkg::ST_USER |-> s_ff.user_io && !s_ff.complete_oe && !s_ff.status_oe)
        else $error("user mode pins wrong");
    a_init_window: assert property ($rose(s_ff.state == fpc_pkg::ST_USER) &&
        !s_ff.ctrl[fpc_pkg::CTRL_USRCLK_BIT] |-> $past(chk_init_cnt) >=
        fpc_pkg::CNT_W'(INIT_CYC - 1) && $past(chk_init_cnt) < fpc_pkg::CNT_W'(INIT_MAX_CYC))
        else $error("init time outside window");
    a_usrclk_delay: assert property ($rose(s_ff.usrclk_en) |-> $past(chk_init_cnt) >=
        fpc_pkg::CNT_W'(fpc_pkg::TCD2CU_CYC - 1)) else $error("user clock enabled early");
    a_initdn_low: assert property (s_ff.state == fpc_pkg::ST_LOAD && ce &&
        s_ff.ctrl[fpc_pkg::CTRL_INITDN_BIT] && s_ff.req_s2 |=> s_ff.initdn_oe)
        else $error("init-done pin not driven low");
    // Initialization starts only after both trailing falls have been counted.
    a_two_falls: assert property (seq_init_entry |-> s_ff.falls == 2'h2)
        else $error("init entered without two falls");
    // Once in user mode, load clock edges must leave the word count alone.
    a_user_no_load: assert property (s_ff.state == fpc_pkg::ST_USER
        && $past(s_ff.state) == fpc_pkg::ST_USER |-> $stable(s_ff.words))
        else $error("load clock acted in user mode");
endmodule // fpc_port

// ### sim/fpc_host.sv
// Behavioural configuration host driving the load clock, data bus and request line.
`timescale 1ns/1ps
module fpc_host (
    // Host-driven pins.
    output logic load_clock,
    output logic [31:0] config_data,
    output logic config_request_n,
    output logic user_init_clock
);
    initial begin
        load_clock = 1'b0;
        config_data = 32'h0000_0000;
        config_request_n = 1'b1;
        user_init_clock = 1'b0;
    end

    // The small offset keeps host edges clear of the sampling clock edges.
    task automatic set_request(input logic v);
        #3 config_request_n = v;
    endtask

    // Each word is held through all of its ratio periods, so trailing clocks follow the last one.
    task automatic send_words(input int n, input int r, input logic [31:0] w);
        #3;
        for (int i = 0; i < n; i++) begin
            config_data = w + 32'h0101_0101 * i;
            for (int j = 0; j < r; j++) begin
                #40 load_clock = 1'b1;
                #40 load_clock = 1'b0;
            end
        end
        // A released bus shows the inverse, so stale data never passes for valid.
        config_data = ~config_data;
    endtask

    task automatic user_clock(input int n);
        repeat (n) begin
            #40 user_init_clock = 1'b1;
            #40 user_init_clock = 1'b0;
        end
    endtask
endmodule // fpc_host

// ### sim/tb_fpc_port.sv
// Self-checking bench for the fast parallel configuration port.
`timescale 1ns/1ps
module tb_fpc_port;
    localparam int POR = 20;
    localparam int STMIN = 30;
    localparam int STMAX = 200;
    localparam int INITMAX = 100;
    localparam int USR = 4;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, load_clock, config_request_n, user_init_clock;
    logic [31:0] config_data;
    logic st_o, st_oe, cd_o, cd_oe, id_o, id_oe, user_io_en, user_clk_en;
    wire status_pin = st_oe ? st_o : 1'b1;
    wire complete_pin = cd_oe ? cd_o : 1'b1;
    int fail_count = 0;
    int tests_run = 0;
    int cyc;
    logic [31:0] rd;
    logic [31:0] w;
    logic [5:0] cfg [8] = '{6'h00, 6'h0c, 6'h01, 6'h09, 6'h05, 6'h0a, 6'h0e, 6'h32};
    int ratio [8] = '{1, 2, 1, 2, 4, 4, 8, 1};
    logic [31:0] mask [3] = '{32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff};

    initial begin
        forever #5 hclk = ~hclk;
    end

    fpc_port #(.POR_CYC(POR), .STATUS_MIN_CYC(STMIN), .STATUS_MAX_CYC(STMAX), .INIT_CYC(20),
        .INIT_MAX_CYC(INITMAX), .USR_EDGES(USR)) i_fpc_port (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .load_clock(load_clock),
        .config_data(config_data), .config_request_n(config_request_n),
        .config_status_n_i(status_pin), .config_status_n_o(st_o), .config_status_n_oe(st_oe),
        .config_complete_o(cd_o), .config_complete_oe(cd_oe), .user_init_clock(user_init_clock),
        .init_done_o(id_o), .init_done_oe(id_oe), .user_io_en(user_io_en),
        .user_clk_en(user_clk_en));

    fpc_host i_fpc_host (.load_clock(load_clock), .config_data(config_data),
        .config_request_n(config_request_n), .user_init_clock(user_init_clock));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One single-word transfer; read data lands in rd.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
        if (n >= 40) begin
            fail_count++;
            give_verdict();
        end
    endtask

    // Waits for a pin to reach a level; cyc holds the cycles taken.
    task automatic wait_for(input int sel, input logic v, input int lim);
        cyc = 0;
        while ((sel == 0 ? status_pin : sel == 1 ? complete_pin :
                sel == 2 ? user_io_en : user_clk_en) !== v) begin
            @(posedge hclk);
            cyc++;
            if (cyc > lim) begin
                fail_count++;
                give_verdict();
            end
        end
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'(st_oe), 32'h1);
        chk(32'(cd_oe), 32'h1);
        wait_for(0, 1'b1, POR + 20);
        chk(32'(cyc >= POR - 2), 32'h1);
        ahb(1'b0, 32'h0000_0000, 32'h0);
        chk(rd, 32'h0000_0002);
        ahb(1'b0, 32'h0000_0004, 32'h0);
        chk(rd, 32'h0000_0010);
        ahb(1'b0, 32'h0000_001c, 32'h0);
        chk(rd, 32'h0000_0000);
        for (int t = 0; t < 8; t++) begin
            w = 32'ha5c3_0000 + 32'(t);
            ahb(1'b1, 32'h0000_0000, {26'h0, cfg[t]});
            ahb(1'b1, 32'h0000_0004, 32'h0000_0003);
            i_fpc_host.set_request(1'b0);
            wait_for(1, 1'b0, 60);
            wait_for(0, 1'b0, 60);
            chk(32'({st_o, cd_o}), 32'h0);
            repeat (200) @(posedge hclk);
            i_fpc_host.set_request(1'b1);
            wait_for(0, 1'b1, STMAX);
            chk(32'(cyc >= STMIN), 32'h1);
            ahb(1'b0, 32'h0000_0008, 32'h0);
            chk(32'(rd[7:4]), 32'(ratio[t]));
            repeat (200) @(posedge hclk);
            i_fpc_host.send_words(2, ratio[t], w);
            chk(32'(complete_pin), 32'h0);
            chk(32'(id_oe), 32'(cfg[t][5]));
            chk(32'(id_o), 32'h0);
            ahb(1'b0, 32'h0000_000c, 32'h0);
            chk(rd, 32'h0000_0002);
            i_fpc_host.send_words(1, ratio[t], w + 32'h0202_0202);
            wait_for(1, 1'b1, 20);
            ahb(1'b0, 32'h0000_0010, 32'h0);
            chk(rd, (w + 32'h0202_0202) & mask[cfg[t][1:0]]);
            i_fpc_host.send_words(2, 1, 32'h0);
            if (cfg[t][4]) begin
                wait_for(3, 1'b1, 40);
                i_fpc_host.user_clock(USR + 2);
            end
            wait_for(2, 1'b1, INITMAX);
            chk(32'(id_oe), 32'h0);
            i_fpc_host.send_words(2, 1, 32'h0);
            ahb(1'b0, 32'h0000_000c, 32'h0);
            chk(rd, 32'h0000_0003);
            $display("test %0d done", t);
        end
        give_verdict();
    end
endmodule // tb_fpc_port
